// File: logic/host_bus_pkg.sv
package host_bus_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int REG_ADDR_W = 6;
	localparam int WAIT_CYCLES = 3;
	localparam int LINE_BEATS = 4;
	localparam int FIFO_DEPTH = 4;
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LINE = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;

	typedef enum logic {
		MODE_ASYNC = 1'b0,
		MODE_SYNC = 1'b1
	} bus_mode_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_WAIT = 2'b01,
		S_TERM = 2'b10,
		S_HOLD = 2'b11
	} slave_state_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_REQ = 3'b001,
		M_OWN = 3'b010,
		M_ADDR = 3'b011,
		M_STRB = 3'b100,
		M_WAIT = 3'b101,
		M_REL = 3'b110
	} master_state_t;

	// Sizes the slave port cannot serve
	function automatic logic slave_size_bad(input bus_mode_t mode, input logic [1:0] size);
		slave_size_bad = (size == SIZE_WORD) || (mode == MODE_ASYNC && size == SIZE_LINE);
	endfunction : slave_size_bad
endpackage : host_bus_pkg

// File: logic/sync_fifo.sv
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	logic push;
	logic pop;

	assign o_in_ready = (count_q != FULL_CNT);
	assign o_out_valid = (count_q != '0);
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_out_data = mem_q[rd_ptr_q];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == LAST_IDX) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == LAST_IDX) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : sync_fifo

// File: logic/host_bus_port.sv
`timescale 1ns/1ps
// What this block does
// R1: Async host sets direction, address, size before address strobe.
// R2: Chip select sampled on a clock edge after the address phase starts.
// R3: Cache burst acknowledge held deasserted during async slave access.
// R4: Three wait cycles before slave termination; read data driven.
// R5: Async slave ends with slave done, or bus fault on error.
// R6: Address strobe removal releases termination and read data.
// R7: Sync host gives transfer start with address, drops it once sampled.
// R8: Burst inhibit asserted during sync slave access.
// R9: Sync slave fault asserts only error acknowledge, ends next edge.
// R10: Good sync slave access waits for transfer acknowledge, then floats data.
// R11: Fetch indicator asserted first, then bus request.
// R12: On grant with grant ack idle: assert grant ack, owner, drop request.
// R13: Control lines first, then address, size and write data.
// R14: Async strobe with burst request; data strobe with it on reads, later on writes.
// R15: Async line burst when slave acknowledges cache burst.
// R16: Async bus fault plus halt means retry.
// R17: Async clean termination starts next address phase if more remain.
// R18: After last acknowledged cycle drop owner and grant ack.
// R19: Sync master asserts in-progress and one-clock transfer start with address.
// R20: Sync line burst when slave leaves burst inhibit unasserted.
// R21: Sync error+ack retries, error alone faults, ack alone continues.
// R22: Refused line burst uses threshold-length bursts.
// R23: Static mode input selects async or sync sequences exclusively.
module host_bus_port import host_bus_pkg::*; #(
	parameter int CNT_W = 16,
	parameter int THR_W = 4
) (
	// Clock, reset and mode strap
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_bus_protocol_sel,
	// Host bus inputs
	input wire logic i_chip_sel_n,
	input wire logic i_addr_strobe_n,
	input wire logic i_xfer_begin_n,
	input wire logic i_rw,
	input wire logic [REG_ADDR_W-1:0] i_addr,
	input wire logic [1:0] i_xfer_size,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic i_xfer_ack_n,
	input wire logic i_xfer_error_ack_n,
	input wire logic i_bus_fault_n,
	input wire logic i_halt_n,
	input wire logic i_sync_termination_n,
	input wire logic i_line_burst_ack_n,
	input wire logic i_burst_inhibit_n,
	input wire logic i_bus_grant_n,
	input wire logic i_grant_ack_n,
	// Host bus outputs
	output logic [DATA_W-1:0] o_data,
	output logic o_data_oe,
	output logic o_slave_done_n,
	output logic o_bus_fault_n,
	output logic o_xfer_error_ack_n,
	output logic o_slave_term_oe,
	output logic o_line_burst_ack_n,
	output logic o_burst_inhibit_n,
	output logic o_burst_ctl_oe,
	output logic o_bus_req_n,
	output logic o_fetch_n,
	output logic o_grant_ack_n,
	output logic o_grant_ack_oe,
	output logic o_master_n,
	output logic o_rw,
	output logic [1:0] o_snoop_ctl,
	output logic [2:0] o_function_code,
	output logic [1:0] o_xfer_type,
	output logic o_ctl_oe,
	output logic [ADDR_W-1:0] o_addr,
	output logic [1:0] o_xfer_size,
	output logic o_addr_oe,
	output logic o_addr_strobe_n,
	output logic o_data_strobe_n,
	output logic o_line_burst_req_n,
	output logic o_xfer_begin_n,
	output logic o_xfer_in_progress_n,
	output logic o_strobe_oe,
	// Internal register port
	output logic [REG_ADDR_W-1:0] o_reg_addr,
	output logic [DATA_W-1:0] o_reg_wdata,
	output logic o_reg_wr,
	output logic o_reg_rd,
	input wire logic [DATA_W-1:0] i_reg_rdata,
	input wire logic i_reg_fault,
	// Master request port
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic i_req_write,
	input wire logic i_req_fetch,
	input wire logic [ADDR_W-1:0] i_req_addr,
	input wire logic [CNT_W-1:0] i_req_words,
	input wire logic [1:0] i_req_snoop,
	input wire logic [2:0] i_req_fc,
	input wire logic [1:0] i_req_type,
	input wire logic [THR_W-1:0] i_threshold,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [DATA_W-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_master_fault
);
	localparam logic [1:0] WAIT_LOAD = 2'(WAIT_CYCLES - 1);
	localparam logic [THR_W-1:0] LINE_LEFT = THR_W'(LINE_BEATS - 1);

	logic bs_s1_q, bs_s2_q, bs_s3_q, bs_f_q;
	bus_mode_t mode_q;
	slave_state_t s_q, s_d;
	master_state_t m_q, m_d;
	logic [1:0] wait_cnt_q;
	logic s_rd_q, s_fault_q;
	logic [1:0] s_size_q;
	logic [REG_ADDR_W-1:0] s_addr_q;
	logic [DATA_W-1:0] s_wdata_q;
	logic [DATA_W-1:0] data_out_q;
	logic bus_req_n_q, fetch_q, wr_q, first_q, fault_q;
	logic [ADDR_W-1:0] addr_q;
	logic [CNT_W-1:0] words_left_q;
	logic [THR_W-1:0] thr_q, own_left_q, own_next;
	logic [1:0] snoop_q, type_q;
	logic [2:0] fc_q;
	logic slave_start, owning, addr_phase, is_async, is_sync;
	logic retry, err, done, burst_ok, more, can_beat, beat_go, fifo_in_ready;

	// Mode strap filter, frozen while any access runs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bs_s1_q <= 1'b0;
			bs_s2_q <= 1'b0;
			bs_s3_q <= 1'b0;
			bs_f_q <= 1'b0;
			mode_q <= MODE_ASYNC;
		end else begin
			bs_s1_q <= i_bus_protocol_sel;
			bs_s2_q <= bs_s1_q;
			bs_s3_q <= bs_s2_q;
			if (bs_s2_q == bs_s3_q) begin
				bs_f_q <= bs_s2_q;
			end
			if (s_q == S_IDLE && m_q == M_IDLE) begin
				mode_q <= bus_mode_t'(bs_f_q); // R23
			end
		end
	end

	assign is_async = (mode_q == MODE_ASYNC);
	assign is_sync = (mode_q == MODE_SYNC);
	assign owning = (m_q == M_OWN) || (m_q == M_ADDR) || (m_q == M_STRB) || (m_q == M_WAIT);
	assign addr_phase = (m_q == M_ADDR) || (m_q == M_STRB) || (m_q == M_WAIT);

	// Slave access start
	assign slave_start = !owning && !i_chip_sel_n
		&& (is_async ? !i_addr_strobe_n : !i_xfer_begin_n); // R1 R2 R7

	always_comb begin
		s_d = s_q;
		case (s_q)
			S_IDLE: if (slave_start) s_d = S_WAIT;
			S_WAIT: if (wait_cnt_q == 2'h0) s_d = S_TERM; // R4
			S_TERM: begin
				if (is_async) begin
					if (i_addr_strobe_n) s_d = S_IDLE; // R6
				end else begin
					s_d = s_fault_q ? S_IDLE : S_HOLD; // R9
				end
			end
			S_HOLD: if (!i_xfer_ack_n) s_d = S_IDLE; // R10
			default: s_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= S_IDLE;
			wait_cnt_q <= 2'h0;
			s_rd_q <= 1'b0;
			s_fault_q <= 1'b0;
			s_size_q <= SIZE_LONG;
			s_addr_q <= '0;
			s_wdata_q <= '0;
		end else begin
			s_q <= s_d;
			if (s_q == S_IDLE && slave_start) begin
				wait_cnt_q <= WAIT_LOAD; // R4
				s_rd_q <= i_rw;
				s_size_q <= i_xfer_size;
				s_addr_q <= i_addr;
				s_wdata_q <= i_data;
			end else if (s_q == S_WAIT) begin
				wait_cnt_q <= wait_cnt_q - 2'h1;
			end
			if (s_q == S_WAIT && wait_cnt_q == 2'h0) begin
				s_fault_q <= slave_size_bad(mode_q, s_size_q) || i_reg_fault; // R5 R9
			end
		end
	end

	assign o_reg_addr = s_addr_q;
	assign o_reg_wdata = s_wdata_q;
	assign o_reg_rd = (s_q == S_WAIT) && (wait_cnt_q == WAIT_LOAD) && s_rd_q;
	assign o_reg_wr = (s_q == S_WAIT) && (wait_cnt_q == WAIT_LOAD) && !s_rd_q;

	// Slave termination
	assign o_slave_done_n = !(s_q == S_TERM && !s_fault_q); // R5
	assign o_bus_fault_n = !(is_async && s_q == S_TERM && s_fault_q); // R5
	assign o_xfer_error_ack_n = !(is_sync && s_q == S_TERM && s_fault_q); // R9
	assign o_slave_term_oe = (s_q != S_IDLE);
	assign o_line_burst_ack_n = 1'b1; // R3
	assign o_burst_inhibit_n = !(is_sync && s_q != S_IDLE); // R8
	assign o_burst_ctl_oe = (s_q != S_IDLE); // R3 R8

	// Master termination decode
	always_comb begin
		if (is_async) begin
			retry = !i_bus_fault_n && !i_halt_n; // R16
			err = !i_bus_fault_n && i_halt_n;
			done = !i_sync_termination_n && i_bus_fault_n && i_halt_n; // R17
			burst_ok = !i_line_burst_ack_n; // R15
		end else begin
			retry = !i_xfer_error_ack_n && !i_xfer_ack_n; // R21
			err = !i_xfer_error_ack_n && i_xfer_ack_n; // R21
			done = !i_xfer_ack_n && i_xfer_error_ack_n; // R21
			burst_ok = i_burst_inhibit_n; // R20
		end
	end

	// Beats left in this ownership
	assign own_next = first_q ? (burst_ok ? LINE_LEFT : thr_q - 1'b1)
		: own_left_q - 1'b1; // R15 R20 R22
	assign more = (words_left_q > CNT_W'(1)) && (own_next != '0);
	assign can_beat = wr_q ? i_wr_valid : fifo_in_ready;
	assign beat_go = (m_q == M_OWN && can_beat)
		|| (m_q == M_WAIT && done && more && wr_q && i_wr_valid);

	always_comb begin
		m_d = m_q;
		case (m_q)
			M_IDLE: if (i_req_valid) m_d = M_REQ;
			M_REQ: if (!bus_req_n_q && !i_bus_grant_n && i_grant_ack_n) m_d = M_OWN; // R12
			M_OWN: if (can_beat) m_d = M_ADDR; // R13
			M_ADDR: m_d = is_sync ? M_WAIT : M_STRB; // R19
			M_STRB: m_d = M_WAIT;
			M_WAIT: begin
				if (retry) m_d = M_ADDR; // R16 R21
				else if (err) m_d = M_REL;
				else if (done) m_d = more ? (beat_go ? M_ADDR : M_OWN) : M_REL; // R17 R21
			end
			M_REL: m_d = (words_left_q != '0) ? M_REQ : M_IDLE;
			default: m_d = M_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			m_q <= M_IDLE;
			bus_req_n_q <= 1'b1;
			fetch_q <= 1'b0;
			wr_q <= 1'b0;
			first_q <= 1'b0;
			fault_q <= 1'b0;
			addr_q <= '0;
			words_left_q <= '0;
			thr_q <= '0;
			own_left_q <= '0;
			snoop_q <= 2'h0;
			type_q <= 2'h0;
			fc_q <= 3'h0;
		end else begin
			m_q <= m_d;
			bus_req_n_q <= !(m_q == M_REQ && m_d == M_REQ); // R11 R12
			fault_q <= (m_q == M_WAIT) && !retry && err; // R21
			if (m_q == M_IDLE && i_req_valid) begin
				fetch_q <= i_req_fetch; // R11
				wr_q <= i_req_write;
				addr_q <= i_req_addr;
				words_left_q <= i_req_words;
				snoop_q <= i_req_snoop;
				fc_q <= i_req_fc;
				type_q <= i_req_type;
				thr_q <= (i_threshold == '0) ? THR_W'(1) : i_threshold;
			end
			if (m_q == M_REQ && m_d == M_OWN) begin
				first_q <= 1'b1;
			end
			if (m_q == M_WAIT && !retry) begin
				if (err) begin
					words_left_q <= '0;
				end else if (done) begin
					words_left_q <= words_left_q - 1'b1;
					addr_q <= addr_q + ADDR_STEP;
					own_left_q <= own_next;
					first_q <= 1'b0;
				end
			end
			if (m_q == M_REL) begin
				if (words_left_q == '0) fetch_q <= 1'b0;
			end
		end
	end

	// Data output register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			data_out_q <= '0;
		end else if (s_q == S_WAIT && wait_cnt_q == 2'h0) begin
			data_out_q <= i_reg_rdata; // R4
		end else if (beat_go && wr_q) begin
			data_out_q <= i_wr_data; // R13
		end
	end

	assign o_data = data_out_q;
	assign o_data_oe = (s_rd_q && ((s_q == S_TERM && !s_fault_q) || s_q == S_HOLD))
		|| (addr_phase && wr_q); // R4 R6 R10 R13
	assign o_wr_ready = beat_go && wr_q;
	assign o_req_ready = (m_q == M_IDLE);
	assign o_master_fault = fault_q;

	// Master pin drive
	assign o_bus_req_n = bus_req_n_q;
	assign o_fetch_n = !fetch_q; // R11
	assign o_grant_ack_n = !owning; // R12 R18
	assign o_master_n = !owning; // R12 R18
	assign o_grant_ack_oe = owning;
	assign o_ctl_oe = owning; // R13
	assign o_rw = !wr_q;
	assign o_snoop_ctl = snoop_q;
	assign o_function_code = fc_q;
	assign o_xfer_type = type_q;
	assign o_addr = addr_q;
	assign o_xfer_size = SIZE_LONG;
	assign o_addr_oe = addr_phase; // R13
	assign o_strobe_oe = owning;
	assign o_addr_strobe_n = !(is_async && (m_q == M_STRB || m_q == M_WAIT)); // R14
	assign o_line_burst_req_n = !(is_async && (m_q == M_STRB || m_q == M_WAIT)); // R14
	assign o_data_strobe_n = !(is_async && (m_q == M_WAIT || (m_q == M_STRB && !wr_q))); // R14
	assign o_xfer_begin_n = !(is_sync && m_q == M_ADDR); // R19
	assign o_xfer_in_progress_n = !(is_sync && addr_phase); // R19

	sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_in_valid(m_q == M_WAIT && done && !wr_q),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_data),
		.o_out_valid(o_rd_valid),
		.i_out_ready(i_rd_ready),
		.o_out_data(o_rd_data)
	);

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_wait3;
		(s_q == S_WAIT) [*3];
	endsequence
	sequence s_term;
		!o_slave_done_n || !o_bus_fault_n || !o_xfer_error_ack_n;
	endsequence
	property p_r2; (s_q == S_IDLE && s_d == S_WAIT) |-> !i_chip_sel_n; endproperty
	a_r2: assert property (p_r2) else $error("no chip select"); // R2
	property p_r4; (s_q == S_IDLE && s_d == S_WAIT) |=> s_wait3 ##1 s_term; endproperty
	a_r4: assert property (p_r4) else $error("wait count wrong"); // R4
	property p_r3; (s_q != S_IDLE && is_async) |-> o_burst_ctl_oe && o_line_burst_ack_n;
	endproperty
	a_r3: assert property (p_r3) else $error("burst ack not held off"); // R3
	property p_r5; (s_q == S_TERM && is_async) |-> (o_slave_done_n != o_bus_fault_n);
	endproperty
	a_r5: assert property (p_r5) else $error("async termination wrong"); // R5
	property p_r6; (s_q == S_TERM && is_async && i_addr_strobe_n)
		|=> o_slave_done_n && o_bus_fault_n && !o_data_oe; endproperty
	a_r6: assert property (p_r6) else $error("no release"); // R6
	property p_r8; (s_q != S_IDLE && is_sync) |-> !o_burst_inhibit_n; endproperty
	a_r8: assert property (p_r8) else $error("burst inhibit missing"); // R8
	property p_r9; $fell(o_xfer_error_ack_n) |-> o_slave_done_n ##1
		(o_xfer_error_ack_n && s_q == S_IDLE); endproperty
	a_r9: assert property (p_r9) else $error("error ack not one cycle"); // R9
	property p_r10; (s_q == S_HOLD && !i_xfer_ack_n) |=> s_q == S_IDLE && !o_data_oe;
	endproperty
	a_r10: assert property (p_r10) else $error("no close on ack"); // R10
	property p_r11; $fell(o_bus_req_n) |-> $stable(o_fetch_n); endproperty
	a_r11: assert property (p_r11) else $error("fetch indicator late"); // R11
	property p_r12; $fell(o_grant_ack_n) |-> !o_master_n && $rose(o_bus_req_n)
		&& $past(!i_bus_grant_n && i_grant_ack_n); endproperty
	a_r12: assert property (p_r12) else $error("grant handshake wrong"); // R12
	property p_r14; $fell(o_addr_strobe_n) |-> !o_line_burst_req_n && o_addr_oe
		&& (o_data_strobe_n == wr_q); endproperty
	a_r14: assert property (p_r14) else $error("async strobe set wrong"); // R14
	property p_r19; $fell(o_xfer_begin_n) |-> !o_xfer_in_progress_n && o_addr_oe
		##1 (o_xfer_begin_n && !o_xfer_in_progress_n); endproperty
	a_r19: assert property (p_r19) else $error("start not one clock"); // R19
	property p_r21; (m_q == M_WAIT && is_sync && !i_xfer_error_ack_n && i_xfer_ack_n)
		|=> o_master_fault && o_master_n; endproperty
	a_r21: assert property (p_r21) else $error("bus fault not raised"); // R21
	property p_r18; (m_q == M_WAIT && !retry && !err && done && !more)
		|=> o_master_n && o_grant_ack_n; endproperty
	a_r18: assert property (p_r18) else $error("bus not released"); // R18
endmodule : host_bus_port

// File: test/host_mem_model.sv
`timescale 1ns/1ps
module host_mem_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Controls
	input wire logic i_sync,
	input wire logic i_line_ok,
	input wire logic [1:0] i_err,
	input wire logic [1:0] i_dly,
	// Bus from the block
	input wire logic i_bus_req_n,
	input wire logic i_as_n,
	input wire logic i_ts_n,
	input wire logic i_rw,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_data,
	// Answers
	output logic o_gnt_n,
	output logic o_sync_termination_n_n,
	output logic o_bus_fault_n_n,
	output logic o_halt_n,
	output logic o_ta_n,
	output logic o_tea_n,
	output logic o_cbk_n,
	output logic o_tbi_n,
	output logic [31:0] o_data
);
	logic [31:0] mem [16];
	logic [1:0] st_q, cnt_q, k_q;
	logic [3:0] a_q;
	logic hit_q, t;
	assign t = st_q == 2'd2;
	// Released data lines show the inverse
	assign o_data = t ? mem[a_q] : ~mem[a_q];
	assign o_sync_termination_n_n = !(t && !i_sync && k_q == 2'd0);
	assign o_bus_fault_n_n = !(t && !i_sync && k_q != 2'd0);
	assign o_halt_n = !(t && !i_sync && k_q == 2'd1);
	assign o_ta_n = !(t && i_sync && k_q != 2'd2);
	assign o_tea_n = !(t && i_sync && k_q != 2'd0);
	assign o_cbk_n = !(t && !i_sync && i_line_ok);
	assign o_tbi_n = !(t && i_sync && !i_line_ok);
	// Arbiter
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_gnt_n <= 1'b1;
		end else begin
			o_gnt_n <= i_bus_req_n;
		end
	end
	// Beat responder
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= 2'd0;
			cnt_q <= 2'd0;
			k_q <= 2'd0;
			a_q <= 4'h0;
			hit_q <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 32'hA5A5_0000 + 32'(i);
			end
		end else begin
			case (st_q)
				2'd0: if (i_sync ? !i_ts_n : !i_as_n) begin
					st_q <= 2'd1;
					cnt_q <= i_dly;
					a_q <= i_addr[5:2];
				end
				2'd1: if (cnt_q == 2'd0) begin
					st_q <= 2'd2;
					k_q <= (i_err == 2'd1 && hit_q) ? 2'd0 : i_err;
					hit_q <= hit_q | (i_err == 2'd1);
				end else begin
					cnt_q <= cnt_q - 2'd1;
				end
				default: begin
					st_q <= 2'd0;
					if (!i_rw && k_q == 2'd0) mem[a_q] <= i_data;
				end
			endcase
			if (i_err == 2'd0) hit_q <= 1'b0;
		end
	end
endmodule : host_mem_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import host_bus_pkg::*;
	int compares, fails;
	logic i_clk, i_reset_n, i_bus_protocol_sel, i_chip_sel_n, i_rw, i_reg_fault, i_req_valid;
	logic i_req_write, i_req_fetch, i_wr_valid, i_rd_ready, h_as_n, h_ts_n, h_ta_n, m_sync;
	logic m_line, m_halt_n, m_gnt_n, m_sync_termination_n_n, m_bus_fault_n_n, m_ta_n, m_tea_n, m_cbk_n, m_tbi_n;
	logic [1:0] i_xfer_size, i_req_snoop, i_req_type, m_err, m_dly;
	logic [2:0] i_req_fc;
	logic [3:0] i_threshold;
	logic [15:0] i_req_words;
	logic [REG_ADDR_W-1:0] i_addr, o_reg_addr;
	logic [31:0] h_data, m_data, i_reg_rdata, i_req_addr, i_wr_data, o_data, o_addr;
	logic [31:0] o_reg_wdata, o_rd_data;
	logic o_data_oe, o_slave_done_n, o_bus_fault_n, o_xfer_error_ack_n, o_slave_term_oe;
	logic o_line_burst_ack_n, o_burst_inhibit_n, o_burst_ctl_oe, o_bus_req_n, o_fetch_n;
	logic o_grant_ack_n, o_grant_ack_oe, o_master_n, o_rw, o_ctl_oe, o_addr_oe, o_addr_strobe_n;
	logic o_data_strobe_n, o_line_burst_req_n, o_xfer_begin_n, o_xfer_in_progress_n;
	logic o_strobe_oe, o_reg_wr, o_reg_rd, o_req_ready, o_wr_ready, o_rd_valid, o_master_fault;
	logic [1:0] o_snoop_ctl, o_xfer_type, o_xfer_size;
	logic [2:0] o_function_code;
	// Shared lines
	wire i_addr_strobe_n = o_strobe_oe ? o_addr_strobe_n : h_as_n;
	wire i_xfer_begin_n = o_strobe_oe ? o_xfer_begin_n : h_ts_n;
	wire [31:0] i_data = o_data_oe ? o_data : (o_master_n ? h_data : m_data);
	wire i_xfer_ack_n = h_ta_n & m_ta_n;
	wire i_xfer_error_ack_n = o_slave_term_oe ? o_xfer_error_ack_n : m_tea_n;
	wire i_bus_fault_n = o_slave_term_oe ? o_bus_fault_n : m_bus_fault_n_n;
	wire i_line_burst_ack_n = o_burst_ctl_oe ? o_line_burst_ack_n : m_cbk_n;
	wire i_burst_inhibit_n = o_burst_ctl_oe ? o_burst_inhibit_n : m_tbi_n;
	wire i_grant_ack_n = o_grant_ack_n | !o_grant_ack_oe;
	host_bus_port host_bus_port_inst (.i_clk, .i_reset_n, .i_bus_protocol_sel, .i_chip_sel_n,
		.i_addr_strobe_n, .i_xfer_begin_n, .i_rw, .i_addr, .i_xfer_size, .i_data, .i_xfer_ack_n,
		.i_xfer_error_ack_n, .i_bus_fault_n, .i_halt_n(m_halt_n), .i_sync_termination_n(m_sync_termination_n_n),
		.i_line_burst_ack_n, .i_burst_inhibit_n, .i_bus_grant_n(m_gnt_n), .i_grant_ack_n, .o_data,
		.o_data_oe, .o_slave_done_n, .o_bus_fault_n, .o_xfer_error_ack_n, .o_slave_term_oe,
		.o_line_burst_ack_n, .o_burst_inhibit_n, .o_burst_ctl_oe, .o_bus_req_n, .o_fetch_n,
		.o_grant_ack_n, .o_grant_ack_oe, .o_master_n, .o_rw, .o_snoop_ctl, .o_function_code,
		.o_xfer_type, .o_ctl_oe, .o_addr, .o_xfer_size, .o_addr_oe, .o_addr_strobe_n,
		.o_data_strobe_n, .o_line_burst_req_n, .o_xfer_begin_n, .o_xfer_in_progress_n,
		.o_strobe_oe, .o_reg_addr, .o_reg_wdata, .o_reg_wr, .o_reg_rd, .i_reg_rdata, .i_reg_fault,
		.i_req_valid, .o_req_ready, .i_req_write, .i_req_fetch, .i_req_addr, .i_req_words,
		.i_req_snoop, .i_req_fc, .i_req_type, .i_threshold, .i_wr_valid, .o_wr_ready, .i_wr_data,
		.o_rd_valid, .i_rd_ready, .o_rd_data, .o_master_fault);
	host_mem_model host_mem_model_inst (.i_clk, .i_reset_n, .i_sync(m_sync), .i_line_ok(m_line),
		.i_err(m_err), .i_dly(m_dly), .i_bus_req_n(o_bus_req_n),
		.i_as_n(o_addr_strobe_n | !o_strobe_oe), .i_ts_n(o_xfer_begin_n | !o_strobe_oe),
		.i_rw(o_rw), .i_addr(o_addr), .i_data, .o_gnt_n(m_gnt_n), .o_sync_termination_n_n(m_sync_termination_n_n),
		.o_bus_fault_n_n(m_bus_fault_n_n), .o_halt_n(m_halt_n), .o_ta_n(m_ta_n), .o_tea_n(m_tea_n),
		.o_cbk_n(m_cbk_n), .o_tbi_n(m_tbi_n), .o_data(m_data));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic close_out;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	task automatic set_mode(input logic m);
		@(posedge i_clk);
		i_bus_protocol_sel <= m;
		m_sync <= m;
		repeat (8) @(posedge i_clk);
	endtask : set_mode
	// Host slave access
	task automatic slave(input logic sy, rd, flt, input logic [1:0] sz);
		int n;
		logic szbad, bad;
		szbad = sz == SIZE_WORD || (!sy && sz == SIZE_LINE);
		bad = szbad || flt;
		@(posedge i_clk);
		i_rw <= rd;
		i_addr <= 6'h24;
		i_xfer_size <= sz;
		h_data <= 32'hC0DE_0001;
		i_reg_fault <= flt;
		if (!sy) @(posedge i_clk);
		i_chip_sel_n <= 1'b0;
		if (sy) h_ts_n <= 1'b0;
		else h_as_n <= 1'b0;
		for (n = 1; n < 9; n++) begin
			@(posedge i_clk);
			h_ts_n <= 1'b1;
			#1;
			if (n == 1 && !szbad) chk("reg_strobe", 1, rd ? o_reg_rd : o_reg_wr);
			if (sy) chk("burst_inhibit", 0, o_burst_inhibit_n);
			else chk("line_ack", 1, o_line_burst_ack_n);
			if (!(o_slave_done_n & o_bus_fault_n & o_xfer_error_ack_n)) break;
		end
		chk("wait_edges", WAIT_CYCLES + 1, 32'(n));
		chk("term", {bad, !(bad && !sy), !(bad && sy)},
			{o_slave_done_n, o_bus_fault_n, o_xfer_error_ack_n});
		if (!bad) chk("data_oe", rd, o_data_oe);
		if (rd && !bad) chk("rdata", i_reg_rdata, o_data);
		if (!rd && !szbad) chk("wreg", {i_addr, h_data[25:0]}, {o_reg_addr, o_reg_wdata[25:0]});
		@(posedge i_clk);
		if (!sy) begin
			h_as_n <= 1'b1;
			i_chip_sel_n <= 1'b1;
			h_data <= ~h_data;
		end
		#1;
		if (sy) begin
			chk("one_cycle", 1, o_slave_done_n & o_xfer_error_ack_n);
			chk("hold_oe", rd && !bad, o_data_oe);
			@(posedge i_clk);
			h_ta_n <= bad;
			i_chip_sel_n <= 1'b1;
			@(posedge i_clk);
			h_ta_n <= 1'b1;
		end
		@(posedge i_clk);
		#1;
		chk("release", 32'h0000_000C,
			{o_slave_done_n, o_bus_fault_n, o_data_oe, o_slave_term_oe});
	endtask : slave
	// Master transfer
	task automatic master(input logic wr, fe, line, input logic [1:0] err, input logic [3:0] thr,
		input int words, stall);
		int n, got, own;
		logic ctl_q, ao_q, as_q, ts_q, mo_q, tk, flt;
		{ctl_q, ao_q, as_q, ts_q, mo_q, tk, flt} = 7'h14;
		@(posedge i_clk);
		{m_line, m_err, m_dly, i_threshold} <= {line, err, err == 2'd0 ? 2'd2 : 2'd0, thr};
		{i_req_write, i_req_fetch, i_wr_valid, i_req_valid} <= {wr, fe, wr, 1'b1};
		i_req_words <= 16'(words);
		i_req_addr <= wr ? 32'h0000_0020 : 32'h0000_0010;
		i_wr_data <= 32'h5A00_0000;
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		for (n = 0; n < 600; n++) begin
			@(posedge i_clk);
			i_rd_ready <= n >= stall;
			if (tk) begin
				got++;
				i_wr_data <= i_wr_data + 32'h0000_0001;
				if (got == words) i_wr_valid <= 1'b0;
			end
			#1;
			tk = wr && o_wr_ready === 1'b1;
			if (o_master_fault === 1'b1) flt = 1'b1;
			if (!wr && o_rd_valid === 1'b1 && i_rd_ready === 1'b1) begin
				chk("rd_data", 32'hA5A5_0004 + 32'(got), o_rd_data);
				got++;
			end
			if (o_bus_req_n === 1'b0) chk("fetch_n", !fe, o_fetch_n);
			if (mo_q === 1'b1 && o_master_n === 1'b0) begin
				own++;
				chk("grant", 2'b10, {o_bus_req_n, o_grant_ack_n});
			end
			if (o_addr_oe === 1'b1 && !ao_q) begin
				chk("ctl_first", 1, ctl_q);
				chk("ctl", {!wr, 9'h0A4}, {o_rw, o_snoop_ctl, o_function_code, o_xfer_type,
					o_xfer_size});
			end
			if (!m_sync && o_addr_strobe_n === 1'b0 && as_q)
				chk("strobes", {1'b0, wr}, {o_line_burst_req_n, o_data_strobe_n});
			if (o_xfer_begin_n === 1'b0)
				chk("ts", 2'b00, {ts_q, o_xfer_in_progress_n});
			if (o_strobe_oe === 1'b1)
				chk("other_strobe", 1, m_sync ? o_addr_strobe_n : o_xfer_begin_n);
			{ctl_q, ao_q, as_q, ts_q, mo_q} = {o_ctl_oe, o_addr_oe, o_addr_strobe_n,
				!o_xfer_begin_n, o_master_n};
			if ((got == words || flt) && o_req_ready === 1'b1 && o_master_n === 1'b1) break;
		end
		chk("idle", 3'b111, {o_req_ready, o_master_n, o_grant_ack_oe == 1'b0});
		chk("fault", err == 2'd2, flt);
		if (!flt) begin
			chk("words", words, got);
			chk("owners", line ? (words + 3) / 4 : (words + thr - 1) / thr, own);
		end
		if (wr && !flt) for (n = 0; n < words; n++)
			chk("mem", 32'h5A00_0000 + 32'(n), host_mem_model_inst.mem[8 + n]);
		m_err <= 2'd0;
	endtask : master
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		#(50 * 20000);
		fails++;
		close_out;
	end
	initial begin
		{i_reset_n, i_bus_protocol_sel, i_rw, i_reg_fault, i_req_valid, i_req_write} = 6'h00;
		{i_req_fetch, i_wr_valid, i_rd_ready, m_sync, m_line} = 5'h00;
		{i_chip_sel_n, h_as_n, h_ts_n, h_ta_n} = 4'hF;
		{i_xfer_size, m_err, m_dly, i_threshold, i_req_words} = 28'h0;
		{i_req_snoop, i_req_fc, i_req_type} = 7'h29;
		{i_addr, h_data, i_req_addr, i_wr_data} = '0;
		i_reg_rdata = 32'h1234_5678;
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (8) @(posedge i_clk);
		chk("reset_idle", 4'hF, {o_req_ready, o_bus_req_n, o_master_n, o_slave_done_n});
		slave(1'b0, 1'b1, 1'b0, SIZE_LONG);
		slave(1'b0, 1'b0, 1'b0, SIZE_BYTE);
		slave(1'b0, 1'b0, 1'b1, SIZE_LONG);
		slave(1'b0, 1'b1, 1'b0, SIZE_LINE);
		master(1'b0, 1'b1, 1'b1, 2'd0, 4'd4, 6, 30);
		master(1'b0, 1'b0, 1'b0, 2'd1, 4'd2, 3, 0);
		master(1'b1, 1'b0, 1'b1, 2'd0, 4'd1, 4, 0);
		master(1'b1, 1'b0, 1'b0, 2'd2, 4'd1, 2, 0);
		set_mode(MODE_SYNC);
		slave(1'b1, 1'b1, 1'b0, SIZE_LONG);
		slave(1'b1, 1'b0, 1'b0, SIZE_WORD);
		slave(1'b1, 1'b0, 1'b1, SIZE_LINE);
		master(1'b0, 1'b0, 1'b1, 2'd1, 4'd1, 4, 0);
		master(1'b1, 1'b1, 1'b0, 2'd0, 4'd2, 2, 0);
		master(1'b0, 1'b0, 1'b0, 2'd2, 4'd1, 1, 0);
		close_out;
	end
endmodule : testbench
